// ### core/fdc_result_status_encoder.sv
`include "fdc_status_defs.svh"
`default_nettype none

module fdc_result_status_encoder
  import fdc_status_pkg::*;
(
  input  wire logic       clock,
  input  wire logic       nrst,
  input  wire logic       cmd_start,
  input  wire cmd_kind_e  cmd_kind,
  input  wire logic       invalid_cmd,
  input  wire logic       poll_abort,
  input  wire logic       exec_end,
  input  wire logic       step_pulse,
  input  wire logic       seek_done,
  input  wire logic       outward_past_zero,
  input  wire logic       sector_advance,
  input  wire logic [7:0] current_sector,
  input  wire logic       crc_id_fail,
  input  wire logic       crc_data_fail,
  input  wire logic       service_miss,
  input  wire logic       sector_not_found,
  input  wire logic       id_read_fail,
  input  wire logic       track_seq_fail,
  input  wire logic       id_mark_found,
  input  wire logic       data_mark_missing,
  input  wire logic       head_address,
  input  wire logic [1:0] unit_select_bits,
  input  wire logic       home_track_input,
  input  wire logic       index_pulse_input,
  input  wire logic       write_protect_input,
  input  wire logic       transfer_end_input,
  input  wire logic       result_read,
  input  wire logic       result_index,
  output logic [7:0]      result_status_zero,
  output logic [7:0]      result_status_one,
  output logic [7:0]      data_reg,
  output logic            result_ready
);

  // ========================================================================
  // Pin synchronisers
  logic home_level;
  logic index_level;
  logic wprot_level;
  logic tend_level;

  pin_sync3 u_home (
    .clock (clock),
    .nrst  (nrst),
    .pin   (home_track_input),
    .level (home_level)
  );

  pin_sync3 u_index (
    .clock (clock),
    .nrst  (nrst),
    .pin   (index_pulse_input),
    .level (index_level)
  );

  pin_sync3 u_wprot (
    .clock (clock),
    .nrst  (nrst),
    .pin   (write_protect_input),
    .level (wprot_level)
  );

  pin_sync3 u_tend (
    .clock (clock),
    .nrst  (nrst),
    .pin   (transfer_end_input),
    .level (tend_level)
  );

  // ========================================================================
  // Command phase tracking
  phase_e    phase;
  cmd_kind_e cmd;
  logic      in_exec;
  logic      exec_done;
  logic      last_read;

  assign in_exec      = (phase == PH_EXEC);
  assign exec_done    = in_exec && exec_end;
  assign last_read    = (phase == PH_RESULT) && result_read && result_index;
  assign result_ready = (phase == PH_RESULT);

  always_ff @(posedge clock) begin
    if (!nrst) begin
      phase <= PH_IDLE;
    end else begin
      case (phase)
        PH_IDLE: begin
          if (cmd_start) begin
            phase <= PH_EXEC;
          end
        end
        PH_EXEC: begin
          if (exec_end) begin
            phase <= PH_RESULT;
          end
        end
        PH_RESULT: begin
          if (cmd_start) begin
            phase <= PH_EXEC;
          end else if (last_read) begin
            phase <= PH_IDLE;
          end
        end
        default: begin
          phase <= PH_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge clock) begin
    if (!nrst) begin
      cmd <= CMD_OTHER;
    end else if (cmd_start && !in_exec) begin
      cmd <= cmd_kind;
    end
  end

  // ========================================================================
  // Command groups
  logic is_rw_data;
  logic is_wp_cmd;
  logic is_mark_search;
  logic is_recal;

  assign is_rw_data     = (cmd == CMD_READ_DATA) || (cmd == CMD_WRITE_DATA);
  assign is_wp_cmd      = (cmd == CMD_WRITE_DATA) ||
                          (cmd == CMD_WRITE_DELETED) ||
                          (cmd == CMD_FORMAT_TRACK);
  assign is_mark_search = is_rw_data || (cmd == CMD_READ_DELETED) ||
                          (cmd == CMD_WRITE_DELETED) ||
                          (cmd == CMD_READ_TRACK) || (cmd == CMD_READ_ID);
  assign is_recal       = (cmd == CMD_RECALIBRATE);

  // ========================================================================
  // Recalibrate step counter, saturating at the limit
  logic [6:0] step_cnt;
  logic       recal_fault;

  always_ff @(posedge clock) begin
    if (!nrst) begin
      step_cnt <= `STEP_CNT_RESET;
    end else if (cmd_start && !in_exec) begin
      step_cnt <= `STEP_CNT_RESET;
    end else if (in_exec && is_recal && step_pulse &&
                 step_cnt != `RECAL_STEP_LIMIT) begin
      step_cnt <= step_cnt + 7'h01;
    end
  end

  assign recal_fault = is_recal && (step_cnt == `RECAL_STEP_LIMIT) &&
                       !home_level;

  // ========================================================================
  // Index pulse counter for the ID mark search
  logic       index_prev;
  logic       index_rise;
  logic [1:0] index_cnt;

  always_ff @(posedge clock) begin
    if (!nrst) begin
      index_prev <= 1'b0;
    end else begin
      index_prev <= index_level;
    end
  end

  assign index_rise = index_level && !index_prev;

  always_ff @(posedge clock) begin
    if (!nrst) begin
      index_cnt <= `INDEX_CNT_RESET;
    end else if ((cmd_start && !in_exec) || id_mark_found) begin
      index_cnt <= `INDEX_CNT_RESET;
    end else if (in_exec && is_mark_search && index_rise &&
                 index_cnt != `INDEX_LIMIT) begin
      index_cnt <= index_cnt + 2'h1;
    end
  end

  // ========================================================================
  // Error accumulators; a set in the clearing cycle wins
  logic new_cmd;
  logic flag_track_zero;
  logic flag_past_end;
  logic flag_crc;
  logic flag_late;
  logic flag_no_sector;
  logic flag_wprot;
  logic flag_no_mark;
  logic seen_invalid;
  logic seen_poll;
  logic seen_tend;
  logic seek_pending;
  logic set_no_mark;

  assign new_cmd     = cmd_start && !in_exec;
  assign set_no_mark = in_exec && ((is_mark_search && index_rise &&
                       index_cnt == (`INDEX_LIMIT - 2'h1) &&
                       !id_mark_found) || data_mark_missing);

  always_ff @(posedge clock) begin
    if (!nrst) begin
      flag_track_zero <= 1'b0;
    end else if (in_exec && cmd == CMD_RELATIVE_SEEK &&
                 outward_past_zero) begin
      flag_track_zero <= 1'b1;
    end else if (new_cmd) begin
      flag_track_zero <= 1'b0;
    end
  end

  always_ff @(posedge clock) begin
    if (!nrst) begin
      flag_past_end <= 1'b0;
    end else if (in_exec && sector_advance &&
                 current_sector == `FINAL_SECTOR) begin
      flag_past_end <= 1'b1;
    end else if (new_cmd) begin
      flag_past_end <= 1'b0;
    end
  end

  always_ff @(posedge clock) begin
    if (!nrst) begin
      flag_crc <= 1'b0;
    end else if (in_exec && (crc_id_fail || crc_data_fail)) begin
      flag_crc <= 1'b1;
    end else if (new_cmd) begin
      flag_crc <= 1'b0;
    end
  end

  always_ff @(posedge clock) begin
    if (!nrst) begin
      flag_late <= 1'b0;
    end else if (in_exec && service_miss) begin
      flag_late <= 1'b1;
    end else if (new_cmd) begin
      flag_late <= 1'b0;
    end
  end

  always_ff @(posedge clock) begin
    if (!nrst) begin
      flag_no_sector <= 1'b0;
    end else if (in_exec &&
                 ((sector_not_found && (cmd == CMD_READ_DATA ||
                   cmd == CMD_READ_DELETED)) ||
                  (id_read_fail && cmd == CMD_READ_ID) ||
                  (track_seq_fail && cmd == CMD_READ_TRACK))) begin
      flag_no_sector <= 1'b1;
    end else if (new_cmd) begin
      flag_no_sector <= 1'b0;
    end
  end

  always_ff @(posedge clock) begin
    if (!nrst) begin
      flag_wprot <= 1'b0;
    end else if (in_exec && is_wp_cmd && wprot_level) begin
      flag_wprot <= 1'b1;
    end else if (new_cmd) begin
      flag_wprot <= 1'b0;
    end
  end

  always_ff @(posedge clock) begin
    if (!nrst) begin
      flag_no_mark <= 1'b0;
    end else if (set_no_mark) begin
      flag_no_mark <= 1'b1;
    end else if (new_cmd) begin
      flag_no_mark <= 1'b0;
    end
  end

  always_ff @(posedge clock) begin
    if (!nrst) begin
      seen_invalid <= 1'b0;
      seen_poll    <= 1'b0;
    end else if (new_cmd) begin
      seen_invalid <= invalid_cmd;
      seen_poll    <= poll_abort;
    end else if (in_exec) begin
      seen_invalid <= seen_invalid || invalid_cmd;
      seen_poll    <= seen_poll || poll_abort;
    end
  end

  always_ff @(posedge clock) begin
    if (!nrst) begin
      seen_tend <= 1'b0;
    end else if (in_exec && tend_level) begin
      seen_tend <= 1'b1;
    end else if (new_cmd) begin
      seen_tend <= 1'b0;
    end
  end

  // Seek completion waits here until a sense interrupt reports it
  always_ff @(posedge clock) begin
    if (!nrst) begin
      seek_pending <= 1'b0;
    end else if (seek_done) begin
      seek_pending <= 1'b1;
    end else if (exec_done && cmd == CMD_SENSE_INT) begin
      seek_pending <= 1'b0;
    end
  end

  // ========================================================================
  // Status byte assembly
  logic [7:0] next_status_zero;
  logic [7:0] next_status_one;
  logic       tend_missing;
  logic       any_error;

  assign tend_missing = is_rw_data && !seen_tend && !tend_level;

  always_comb begin
    next_status_one                 = `STATUS_RESET;
    next_status_one[`ST1_PAST_END]  = flag_past_end || tend_missing;
    next_status_one[`ST1_CRC]       = flag_crc;
    next_status_one[`ST1_LATE]      = flag_late;
    next_status_one[`ST1_NO_SECTOR] = flag_no_sector;
    next_status_one[`ST1_WPROT]     = flag_wprot;
    next_status_one[`ST1_NO_MARK]   = flag_no_mark;
  end

  assign any_error = (next_status_one != `STATUS_RESET) ||
                     flag_track_zero || recal_fault;

  always_comb begin
    next_status_zero = `STATUS_RESET;
    if (seen_poll) begin
      next_status_zero[`ST0_CLASS_HI:`ST0_CLASS_LO] = `CLASS_POLLING;
    end else if (seen_invalid) begin
      next_status_zero[`ST0_CLASS_HI:`ST0_CLASS_LO] = `CLASS_INVALID;
    end else if (any_error) begin
      next_status_zero[`ST0_CLASS_HI:`ST0_CLASS_LO] = `CLASS_ABNORMAL;
    end else begin
      next_status_zero[`ST0_CLASS_HI:`ST0_CLASS_LO] = `CLASS_NORMAL;
    end
    next_status_zero[`ST0_SEEK_END]    = seek_pending || seek_done;
    next_status_zero[`ST0_TRACK_FAULT] = flag_track_zero || recal_fault;
    next_status_zero[`ST0_HEAD]        = head_address;
    next_status_zero[`ST0_UNIT_HI:`ST0_UNIT_LO] = unit_select_bits;
  end

  // ========================================================================
  // Captured result bytes, held through the result phase
  always_ff @(posedge clock) begin
    if (!nrst) begin
      result_status_zero <= `STATUS_RESET;
      result_status_one  <= `STATUS_RESET;
    end else if (exec_done) begin
      result_status_zero <= next_status_zero;
      result_status_one  <= next_status_one;
    end
  end

  // ========================================================================
  // Data register read path
  always_ff @(posedge clock) begin
    if (!nrst) begin
      data_reg <= `DATA_RESET;
    end else if (phase == PH_RESULT && result_read) begin
      data_reg <= result_index ? result_status_one
                               : result_status_zero;
    end
  end

  // ========================================================================
  // Assertions
  default clocking cb @(posedge clock); endclocking
  default disable iff (!nrst);

  sequence s_exec_end;
    in_exec && exec_end;
  endsequence

  sequence s_read_zero;
    phase == PH_RESULT && result_read && !result_index;
  endsequence

  property p_hold;
    phase == PH_RESULT && !cmd_start |=> $stable(result_status_zero) &&
      $stable(result_status_one);
  endproperty
  a_hold: assert property (p_hold) else $error("status changed in result");

  property p_invalid;
    s_exec_end ##0 (seen_invalid && !seen_poll) |=>
      result_status_zero[`ST0_CLASS_HI:`ST0_CLASS_LO] == `CLASS_INVALID;
  endproperty
  a_invalid: assert property (p_invalid) else $error("bad invalid class");

  property p_unused;
    !result_status_zero[3] && !result_status_one[6] && !result_status_one[3];
  endproperty
  a_unused: assert property (p_unused) else $error("unused bit set");

  property p_unit;
    s_exec_end |=> result_status_zero[1:0] == $past(unit_select_bits) &&
      result_status_zero[2] == $past(head_address);
  endproperty
  a_unit: assert property (p_unit) else $error("unit or head wrong");

  property p_read_zero;
    s_read_zero |=> data_reg == result_status_zero;
  endproperty
  a_read_zero: assert property (p_read_zero) else $error("bad byte read");

  property p_wprot;
    in_exec && is_wp_cmd && wprot_level && !exec_end ##1 exec_end && in_exec
      |=> result_status_one[1];
  endproperty
  a_wprot: assert property (p_wprot) else $error("protect missed");

  property p_tend;
    s_exec_end ##0 (is_rw_data && !seen_tend && !tend_level) |=>
      result_status_one[7] && result_status_zero[7:6] != 2'h0;
  endproperty
  a_tend: assert property (p_tend) else $error("end missing not flagged");

  property p_recal;
    s_exec_end ##0 (is_recal && step_cnt == `RECAL_STEP_LIMIT &&
      !home_level) |=> result_status_zero[`ST0_TRACK_FAULT];
  endproperty
  a_recal: assert property (p_recal) else $error("recal fault missed");

  property p_index;
    in_exec && is_mark_search && index_rise && index_cnt == 2'h1 &&
      !id_mark_found |=> flag_no_mark;
  endproperty
  a_index: assert property (p_index) else $error("mark miss lost");

endmodule

`default_nettype wire

// ### core/fdc_status_defs.svh
`ifndef FDC_STATUS_DEFS_SVH
`define FDC_STATUS_DEFS_SVH

// ==========================================================================
// First status byte fields
`define ST0_CLASS_HI     7
`define ST0_CLASS_LO     6
`define ST0_SEEK_END     5
`define ST0_TRACK_FAULT  4
`define ST0_UNUSED       3
`define ST0_HEAD         2
`define ST0_UNIT_HI      1
`define ST0_UNIT_LO      0

// ==========================================================================
// Second status byte fields
`define ST1_PAST_END     7
`define ST1_UNUSED_HI    6
`define ST1_CRC          5
`define ST1_LATE         4
`define ST1_UNUSED_LO    3
`define ST1_NO_SECTOR    2
`define ST1_WPROT        1
`define ST1_NO_MARK      0

// ==========================================================================
// Termination classes
`define CLASS_NORMAL     2'h0
`define CLASS_ABNORMAL   2'h1
`define CLASS_INVALID    2'h2
`define CLASS_POLLING    2'h3

// ==========================================================================
// Values and limits
`define STATUS_RESET     8'h00
`define DATA_RESET       8'h00
`define RECAL_STEP_LIMIT 7'h50
`define STEP_CNT_RESET   7'h00
`define FINAL_SECTOR     8'hFF
`define INDEX_LIMIT      2'h2
`define INDEX_CNT_RESET  2'h0
`define SYNC_RESET       3'h0

`endif

// ### core/fdc_status_pkg.sv
`default_nettype none

package fdc_status_pkg;

  typedef enum logic [3:0] {
    CMD_OTHER         = 4'h0,
    CMD_READ_DATA     = 4'h1,
    CMD_READ_DELETED  = 4'h2,
    CMD_WRITE_DATA    = 4'h3,
    CMD_WRITE_DELETED = 4'h4,
    CMD_READ_TRACK    = 4'h5,
    CMD_READ_ID       = 4'h6,
    CMD_FORMAT_TRACK  = 4'h7,
    CMD_SEEK          = 4'h8,
    CMD_RELATIVE_SEEK = 4'h9,
    CMD_RECALIBRATE   = 4'hA,
    CMD_SENSE_INT     = 4'hB
  } cmd_kind_e;

  typedef enum logic [1:0] {
    PH_IDLE   = 2'b00,
    PH_EXEC   = 2'b01,
    PH_RESULT = 2'b10
  } phase_e;

endpackage

`default_nettype wire

// ### core/pin_sync3.sv
`include "fdc_status_defs.svh"
`default_nettype none

// ==========================================================================
// Three-stage pin synchroniser; level follows once stages two and three agree
module pin_sync3 (
  input  wire logic clock,
  input  wire logic nrst,
  input  wire logic pin,
  output logic      level
);

  logic [2:0] stage;

  always_ff @(posedge clock) begin
    if (!nrst) begin
      stage <= `SYNC_RESET;
    end else begin
      stage <= {stage[1:0], pin};
    end
  end

  always_ff @(posedge clock) begin
    if (!nrst) begin
      level <= 1'b0;
    end else if (stage[1] == stage[2]) begin
      level <= stage[2];
    end
  end

endmodule

`default_nettype wire

// ### test/fdc_host_model.sv
`default_nettype none

// ==========================================================================
// Host processor reading result bytes through the data register
module fdc_host_model #(
  parameter int LAG = 0
) (
  input  wire logic       clock,
  input  wire logic       result_ready,
  input  wire logic [7:0] data_reg,
  output logic            result_read,
  output logic            result_index
);
  timeunit 1ns;
  timeprecision 1ps;

  int lag = LAG;

  initial begin
    result_read = 1'b0;
    result_index = 1'b1;
  end

  // One read; the caller decides whether the device is ready for it
  task automatic read_byte(input logic idx, output logic [7:0] data);
    repeat (lag) @(posedge clock);
    @(posedge clock);
    result_read <= 1'b1;
    result_index <= idx;
    @(posedge clock);
    result_read <= 1'b0;
    // Index is meaningless while idle, so it does not keep the last value
    result_index <= ~idx;
    @(posedge clock);
    data = data_reg;
  endtask
endmodule

`default_nettype wire

// ### test/fdc_result_status_encoder_tb_top.sv
`default_nettype none

module fdc_result_status_encoder_tb_top import fdc_status_pkg::*;;
  timeunit 1ns;
  timeprecision 1ps;

  localparam logic [15:0] ev_start = 16'h0001, ev_inv = 16'h0002,
    ev_poll = 16'h0004, ev_end = 16'h0008, ev_step = 16'h0010,
    ev_seek = 16'h0020, ev_out = 16'h0040, ev_adv = 16'h0080,
    ev_crci = 16'h0100, ev_crcd = 16'h0200, ev_late = 16'h0400,
    ev_nsec = 16'h0800, ev_idrf = 16'h1000, ev_tseq = 16'h2000,
    ev_idm = 16'h4000, ev_nomk = 16'h8000;

  logic        clock;
  logic        nrst        = 1'b0;
  logic [15:0] evt         = 16'h0000;
  cmd_kind_e   cmd_kind    = CMD_OTHER;
  logic        hd          = 1'b1;
  logic [1:0]  us          = 2'h3;
  logic [7:0]  cur         = 8'h00;
  logic        wp_pin      = 1'b0;
  logic        tc_pin      = 1'b0;
  logic        home_pin    = 1'b0;
  logic        idx_pin     = 1'b0;
  logic        result_read;
  logic        result_index;
  logic [7:0]  result_status_zero;
  logic [7:0]  result_status_one;
  logic [7:0]  data_reg;
  logic        result_ready;
  logic [7:0]  d;
  int          n_fail      = 0;
  int          check_count = 0;
  int          cycles      = 0;
  cmd_kind_e   nd_cmd[3]   = '{CMD_READ_DELETED, CMD_READ_ID, CMD_READ_TRACK};
  logic [15:0] nd_evt[3]   = '{ev_nsec, ev_idrf, ev_tseq};
  cmd_kind_e   wp_cmd[3]   = '{CMD_WRITE_DATA, CMD_WRITE_DELETED,
                               CMD_FORMAT_TRACK};
  logic [15:0] cls_evt[3]  = '{ev_inv, ev_poll, ev_inv | ev_poll};
  logic [1:0]  cls_exp[3]  = '{2'h2, 2'h3, 2'h3};

  fdc_result_status_encoder u_dut (
    .clock(clock), .nrst(nrst), .cmd_start(evt[0]), .cmd_kind(cmd_kind),
    .invalid_cmd(evt[1]), .poll_abort(evt[2]), .exec_end(evt[3]),
    .step_pulse(evt[4]), .seek_done(evt[5]), .outward_past_zero(evt[6]),
    .sector_advance(evt[7]), .current_sector(cur), .crc_id_fail(evt[8]),
    .crc_data_fail(evt[9]), .service_miss(evt[10]),
    .sector_not_found(evt[11]), .id_read_fail(evt[12]),
    .track_seq_fail(evt[13]), .id_mark_found(evt[14]),
    .data_mark_missing(evt[15]), .head_address(hd),
    .unit_select_bits(us), .home_track_input(home_pin),
    .index_pulse_input(idx_pin), .write_protect_input(wp_pin),
    .transfer_end_input(tc_pin), .result_read(result_read),
    .result_index(result_index), .result_status_zero(result_status_zero),
    .result_status_one(result_status_one), .data_reg(data_reg),
    .result_ready(result_ready));

  fdc_host_model #(.LAG(0)) u_host (
    .clock(clock), .result_ready(result_ready), .data_reg(data_reg),
    .result_read(result_read), .result_index(result_index));

  initial begin
    clock = 1'b0;
    forever #2 clock = ~clock;
  end

  always @(posedge clock) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      n_fail++;
      close_out();
    end
  end

  // ========================================================================
  // Shared tasks
  task automatic close_out();
    $display("Checks %0d, mismatches %0d", check_count, n_fail);
    if (n_fail == 0 && check_count > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    check_count++;
    if (seen !== exp) begin
      n_fail++;
      $display("Error at %0t: saw %h, expected %h", $time, seen, exp);
    end
  endtask

  function automatic logic [7:0] s0(input logic [1:0] c, input logic se,
                                    input logic ec);
    return {c, se, ec, 1'b0, hd, us};
  endfunction

  task automatic fire(input logic [15:0] m);
    @(posedge clock);
    evt <= m;
    @(posedge clock);
    evt <= 16'h0000;
  endtask

  task automatic start(input cmd_kind_e k, input logic [15:0] m);
    @(posedge clock);
    cmd_kind <= k;
    evt <= ev_start | m;
    @(posedge clock);
    evt <= 16'h0000;
  endtask

  // Pins pass a synchroniser, so each level is held long enough to land
  task automatic settle();
    repeat (6) @(posedge clock);
  endtask

  task automatic tc_pulse();
    tc_pin <= 1'b1;
    settle();
    tc_pin <= 1'b0;
    settle();
  endtask

  task automatic idx_pulse();
    idx_pin <= 1'b1;
    settle();
    idx_pin <= 1'b0;
    settle();
  endtask

  // End execution, then read both bytes and probe the hold behaviour
  task automatic finish_cmd(input logic [7:0] e0, input logic [7:0] e1);
    int n;
    fire(ev_end);
    n = 0;
    @(negedge clock);
    while (result_ready !== 1'b1 && n < 8) begin
      @(negedge clock);
      n++;
    end
    check({7'h00, result_ready}, 8'h01);
    check(result_status_zero, e0);
    check(result_status_one, e1);
    u_host.read_byte(1'b0, d);
    check(d, e0);
    fire(ev_crcd | ev_late | ev_end);
    u_host.read_byte(1'b1, d);
    check(d, e1);
    check(result_status_one, e1);
    @(negedge clock);
    check({7'h00, result_ready}, 8'h00);
    u_host.read_byte(1'b0, d);
    check(d, e1);
  endtask

  // ========================================================================
  // Scenarios
  initial begin
    repeat (3) @(posedge clock);
    nrst <= 1'b1;
    settle();
    check(result_status_zero, 8'h00);
    check(result_status_one, 8'h00);
    u_host.read_byte(1'b0, d);
    check(d, 8'h00);
    start(CMD_READ_DATA, 16'h0000);
    tc_pulse();
    finish_cmd(s0(2'h0, 1'b0, 1'b0), 8'h00);
    hd <= 1'b0;
    us <= 2'h2;
    start(CMD_READ_DATA, 16'h0000);
    fire(ev_crcd);
    finish_cmd(s0(2'h1, 1'b0, 1'b0), 8'hA0);
    start(CMD_READ_DATA, 16'h0000);
    fire(ev_crci | ev_late | ev_nsec | ev_nomk);
    tc_pulse();
    finish_cmd(s0(2'h1, 1'b0, 1'b0), 8'h35);
    for (int i = 0; i < 3; i++) begin
      start(nd_cmd[i], 16'h0000);
      fire(nd_evt[i]);
      finish_cmd(s0(2'h1, 1'b0, 1'b0), 8'h04);
    end
    for (int i = 0; i < 3; i++) begin
      start(wp_cmd[i], 16'h0000);
      wp_pin <= 1'b1;
      tc_pulse();
      wp_pin <= 1'b0;
      finish_cmd(s0(2'h1, 1'b0, 1'b0), 8'h02);
    end
    for (int i = 0; i < 2; i++) begin
      cur <= 8'hFE + 8'(i);
      start(CMD_READ_DELETED, 16'h0000);
      fire(ev_adv);
      finish_cmd(s0(2'(i), 1'b0, 1'b0), 8'(i) << 7);
    end
    for (int i = 0; i < 2; i++) begin
      start(CMD_READ_DELETED, 16'h0000);
      idx_pulse();
      if (i == 1) fire(ev_idm);
      idx_pulse();
      finish_cmd(s0(2'(1 - i), 1'b0, 1'b0), 8'(1 - i));
    end
    u_host.lag = 2;
    for (int i = 0; i < 3; i++) begin
      home_pin <= (i == 2);
      settle();
      start(CMD_RECALIBRATE, 16'h0000);
      repeat (i == 0 ? 79 : 80) fire(ev_step);
      finish_cmd(s0(2'(i == 1), 1'b0, i == 1), 8'h00);
    end
    home_pin <= 1'b0;
    start(CMD_RELATIVE_SEEK, 16'h0000);
    fire(ev_out);
    finish_cmd(s0(2'h1, 1'b0, 1'b1), 8'h00);
    fire(ev_seek);
    start(CMD_SENSE_INT, 16'h0000);
    finish_cmd(s0(2'h0, 1'b1, 1'b0), 8'h00);
    start(CMD_SENSE_INT, 16'h0000);
    finish_cmd(s0(2'h0, 1'b0, 1'b0), 8'h00);
    for (int i = 0; i < 3; i++) begin
      start(CMD_READ_DELETED, cls_evt[i]);
      fire(ev_crcd);
      finish_cmd(s0(cls_exp[i], 1'b0, 1'b0), 8'h20);
    end
    close_out();
  end
endmodule

`default_nettype wire
